/* src/pmr_bank.sv */
// volatile power result register bank
`timescale 1ns/100ps
// Summary of operation
// - RMS voltage unsigned in word rms_voltage_current low
// - RMS current in word rms_voltage_current high
// - signed active power in word active_reactive_power low
// - unsigned reactive power in word active_reactive_power high
// - apparent power magnitude in word apparent_power_and_factor low
// - signed power factor bits 26:16 of apparent_power_and_factor
// - bit 27 high means current lags
// - bit 28 high means power consumed
// - sample count bits 9:0 of sample_count
// - overcurrent latch sticky, write one clears
module pmr_bank (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire pmr_pkg::pmr_req_t req_i, // one-cycle access strobes
  input wire logic res_valid_i, // new result set ready
  input wire pmr_pkg::pmr_result_t res_i,
  input wire pmr_pkg::pmr_event_t evt_i,
  output logic [31:0] rdata_o,
  output logic rvalid_o,
  output logic customer_mode_o
);
  pmr_pkg::pmr_result_t snap; // frozen result set
  logic [31:0] rdata_nxt; // read mux value
  logic latch_flag; // sticky overcurrent
  logic flag_clr; // write one to latch bit
  logic [31:0] key_r; // unlock key word
  logic [31:0] flags_word; // live event word

  // write strobe aimed at one word, shared by the write decodes and the checks
  function automatic logic wr_hit(input pmr_pkg::pmr_req_t q, input logic [7:0] a);
    wr_hit = q.wr && (q.addr == a);
  endfunction : wr_hit

  // read strobe aimed at one word, used by the checks
  function automatic logic rd_hit(input pmr_pkg::pmr_req_t q, input logic [7:0] a);
    rd_hit = q.rd && (q.addr == a);
  endfunction : rd_hit

  // result snapshot
  pmr_capture u_capture (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .load_i(res_valid_i),
    .res_i(res_i),
    .snap_o(snap)
  );

  // clear only on a write to the flag word with the latch bit set
  // a write of zero leaves the latch alone, so a host may write back what it read
  assign flag_clr = wr_hit(req_i, pmr_pkg::ADDR_FLAGS)
    && req_i.wdata[pmr_pkg::FLG_LATCH];

  // overcurrent latch
  pmr_sticky u_latch (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .set_i(evt_i.overcurrent),
    .clr_i(flag_clr),
    .flag_o(latch_flag)
  );

  // event word: live levels plus latch, rest zero
  always_comb begin
    flags_word = pmr_pkg::WORD_RST;
    flags_word[pmr_pkg::FLG_ZC] = evt_i.zero_cross;
    flags_word[pmr_pkg::FLG_FAULT] = evt_i.overcurrent;
    flags_word[pmr_pkg::FLG_LATCH] = latch_flag;
    flags_word[pmr_pkg::FLG_OV] = evt_i.overvoltage;
    flags_word[pmr_pkg::FLG_UV] = evt_i.undervoltage;
  end

  // unlock key: the only writable word besides the flag clear
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      key_r <= pmr_pkg::WORD_RST;
    end else if (wr_hit(req_i, pmr_pkg::ADDR_KEY)) begin
      key_r <= req_i.wdata;
    end
  end

  // customer mode follows the key; registered for a clean output
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      customer_mode_o <= 1'b0;
    end else begin
      customer_mode_o <= (key_r == pmr_pkg::UNLOCK_CODE);
    end
  end

  // read decode; unmapped words and unused bits read zero
  always_comb begin
    rdata_nxt = pmr_pkg::WORD_RST;
    unique case (req_i.addr)
      pmr_pkg::ADDR_RMS_VI: begin
        rdata_nxt[pmr_pkg::LO_LSB +: 16] = snap.vrms;
        rdata_nxt[pmr_pkg::HI_LSB +: 16] = snap.irms;
      end
      pmr_pkg::ADDR_POWER: begin
        rdata_nxt[pmr_pkg::LO_LSB +: 16] = snap.p_act;
        rdata_nxt[pmr_pkg::HI_LSB +: 16] = snap.p_react;
      end
      pmr_pkg::ADDR_APP_PF: begin
        rdata_nxt[pmr_pkg::LO_LSB +: 16] = snap.p_app;
        rdata_nxt[pmr_pkg::PF_LSB +: 11] = snap.pf;
        rdata_nxt[pmr_pkg::ANGLE_BIT] = snap.angle_lag;
        rdata_nxt[pmr_pkg::DIR_BIT] = snap.consuming;
      end
      pmr_pkg::ADDR_SAMPLES: begin
        rdata_nxt[9:0] = snap.n_samples;
      end
      pmr_pkg::ADDR_INST_VI: begin
        rdata_nxt[pmr_pkg::LO_LSB +: 16] = snap.v_inst;
        rdata_nxt[pmr_pkg::HI_LSB +: 16] = snap.i_inst;
      end
      pmr_pkg::ADDR_INST_P: begin
        rdata_nxt[pmr_pkg::LO_LSB +: 16] = snap.p_inst;
      end
      pmr_pkg::ADDR_FLAGS: begin
        rdata_nxt = flags_word;
      end
      pmr_pkg::ADDR_KEY: begin
        rdata_nxt = key_r;
      end
      pmr_pkg::ADDR_UNLOCK: begin
        rdata_nxt[0] = customer_mode_o;
      end
      default: begin
        rdata_nxt = pmr_pkg::WORD_RST;
      end
    endcase
  end

  // read answer one cycle after the strobe; writes give no answer
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      rdata_o <= pmr_pkg::WORD_RST;
      rvalid_o <= 1'b0;
    end else begin
      rvalid_o <= req_i.rd;
      if (req_i.rd) begin
        rdata_o <= rdata_nxt;
      end
    end
  end

  // checks: answers compare with the snapshot as it stood at the read edge,
  // since a load in the read cycle only shows up in the following reads

  // writes to result words leave the snapshot alone
  a_result_ro: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    !res_valid_i |=> snap == $past(snap))
    else $error("result changed by write");

  // sample word carries nothing above its count
  a_samples_top: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    rd_hit(req_i, pmr_pkg::ADDR_SAMPLES) |=> rdata_o[31:10] == 22'h0)
    else $error("sample word high bits set");

  // angle and direction bits, top of the word zero
  a_pf_fields: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    rd_hit(req_i, pmr_pkg::ADDR_APP_PF) |=> rdata_o[28] == $past(snap.consuming)
    && rdata_o[27] == $past(snap.angle_lag) && rdata_o[31:29] == 3'h0)
    else $error("angle or direction wrong");

  // whole rms word
  a_rms_word: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    rd_hit(req_i, pmr_pkg::ADDR_RMS_VI) |=> rdata_o == $past({snap.irms, snap.vrms}))
    else $error("rms word wrong");

  // whole power word
  a_power_word: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    rd_hit(req_i, pmr_pkg::ADDR_POWER) |=> rdata_o == $past({snap.p_react, snap.p_act}))
    else $error("power word wrong");

  // power factor and apparent power side by side
  a_pf_value: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    rd_hit(req_i, pmr_pkg::ADDR_APP_PF) |=> rdata_o[26:0] == $past({snap.pf, snap.p_app}))
    else $error("pf word wrong");

  // a hole in the map reads zero
  a_unmapped_zero: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    rd_hit(req_i, 8'h23) |=> rdata_o == 32'h0)
    else $error("unmapped word not zero");

  // a clear with no event in the same cycle drops the latch
  a_latch_clear: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    flag_clr && !evt_i.overcurrent |=> !latch_flag)
    else $error("latch not cleared");

  // rms current sits in the high half
  a_irms_high: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    rd_hit(req_i, pmr_pkg::ADDR_RMS_VI) |=> rdata_o[31:16] == $past(snap.irms))
    else $error("rms current half wrong");

  // reactive power sits in the high half
  a_preact_high: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    rd_hit(req_i, pmr_pkg::ADDR_POWER) |=> rdata_o[31:16] == $past(snap.p_react))
    else $error("reactive power half wrong");

  // apparent power sits in the low half
  a_papp_low: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    rd_hit(req_i, pmr_pkg::ADDR_APP_PF) |=> rdata_o[15:0] == $past(snap.p_app))
    else $error("apparent power half wrong");

  // direction bit on its own
  a_dir_bit: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    rd_hit(req_i, pmr_pkg::ADDR_APP_PF) |=> rdata_o[pmr_pkg::DIR_BIT] == $past(snap.consuming))
    else $error("direction bit wrong");

  // sample count value in the low ten bits
  a_count_value: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    rd_hit(req_i, pmr_pkg::ADDR_SAMPLES) |=> rdata_o[9:0] == $past(snap.n_samples))
    else $error("sample count wrong");

  // latch bit as read matches the latch at the read edge
  a_flag_latch: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    rd_hit(req_i, pmr_pkg::ADDR_FLAGS) |=> rdata_o[pmr_pkg::FLG_LATCH] == $past(latch_flag))
    else $error("latch bit read wrong");

  // an overcurrent event always lands in the latch
  a_latch_event: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    evt_i.overcurrent |=> latch_flag)
    else $error("overcurrent not latched");

  // the latch never rises without an event
  a_latch_idle: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    !latch_flag && !evt_i.overcurrent |=> !latch_flag)
    else $error("latch rose without event");

  // live fault bit follows the event level at the read edge
  a_flag_live: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    rd_hit(req_i, pmr_pkg::ADDR_FLAGS) |=> rdata_o[pmr_pkg::FLG_FAULT] == $past(evt_i.overcurrent))
    else $error("fault bit read wrong");

  // unused flag bits read zero
  a_flags_top: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    rd_hit(req_i, pmr_pkg::ADDR_FLAGS) |=> rdata_o[31:5] == 27'h0)
    else $error("flag word high bits set");

  // unlock word carries one bit only
  a_unlock_top: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    rd_hit(req_i, pmr_pkg::ADDR_UNLOCK) |=> rdata_o[31:1] == 31'h0)
    else $error("unlock word high bits set");

  // unlock bit shows the mode at the read edge
  a_unlock_value: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    rd_hit(req_i, pmr_pkg::ADDR_UNLOCK) |=> rdata_o[0] == $past(customer_mode_o))
    else $error("unlock bit wrong");

  // instantaneous power word has an empty high half
  a_instp_top: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    rd_hit(req_i, pmr_pkg::ADDR_INST_P) |=> rdata_o[31:16] == 16'h0)
    else $error("instant power high bits set");

  // instantaneous power value in the low half
  a_instp_low: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    rd_hit(req_i, pmr_pkg::ADDR_INST_P) |=> rdata_o[15:0] == $past(snap.p_inst))
    else $error("instant power wrong");

  // instantaneous voltage and current word
  a_instvi_word: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    rd_hit(req_i, pmr_pkg::ADDR_INST_VI) |=> rdata_o == $past({snap.i_inst, snap.v_inst}))
    else $error("instant word wrong");

  // key word reads back what was stored
  a_key_readback: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    rd_hit(req_i, pmr_pkg::ADDR_KEY) |=> rdata_o == $past(key_r))
    else $error("key readback wrong");

  // a key write is stored whole
  a_key_store: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    wr_hit(req_i, pmr_pkg::ADDR_KEY) |=> key_r == $past(req_i.wdata))
    else $error("key not stored");

  // writes elsewhere never touch the key
  a_key_keep: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    !wr_hit(req_i, pmr_pkg::ADDR_KEY) |=> key_r == $past(key_r))
    else $error("key changed without write");

  // mode trails the key compare by one cycle
  a_mode_follow: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    1'b1 |=> customer_mode_o == $past(key_r == pmr_pkg::UNLOCK_CODE))
    else $error("customer mode wrong");

  // every read strobe gets its answer strobe
  a_rvalid_pulse: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    req_i.rd |=> rvalid_o)
    else $error("read answer missing");

  // no answer strobe without a read
  a_rvalid_quiet: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    !req_i.rd |=> !rvalid_o)
    else $error("answer without read");

  // read data stands until the next read
  a_rdata_hold: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    !req_i.rd |=> rdata_o == $past(rdata_o))
    else $error("read data moved without read");

  // reset clears every output one edge later
  a_reset_quiet: assert property (@(posedge clk_i)
    !rst_n_i |=> rdata_o == 32'h0 && !rvalid_o && !customer_mode_o)
    else $error("outputs not cleared by reset");
endmodule : pmr_bank

/* src/pmr_pkg.sv */
// package: register map, field layout and carriers of the power result bank
package pmr_pkg;
  // word addresses of the register window
  localparam logic [7:0] ADDR_RMS_VI = 8'h20;
  localparam logic [7:0] ADDR_POWER = 8'h21;
  localparam logic [7:0] ADDR_APP_PF = 8'h22;
  localparam logic [7:0] ADDR_SAMPLES = 8'h25;
  localparam logic [7:0] ADDR_INST_VI = 8'h2A;
  localparam logic [7:0] ADDR_INST_P = 8'h2C;
  localparam logic [7:0] ADDR_FLAGS = 8'h2D;
  localparam logic [7:0] ADDR_KEY = 8'h2F;
  localparam logic [7:0] ADDR_UNLOCK = 8'h30;
  // field positions
  localparam int LO_LSB = 0;
  localparam int HI_LSB = 16;
  localparam int PF_LSB = 16;
  localparam int ANGLE_BIT = 27;
  localparam int DIR_BIT = 28;
  localparam int FLG_ZC = 0;
  localparam int FLG_FAULT = 1;
  localparam int FLG_LATCH = 2;
  localparam int FLG_OV = 3;
  localparam int FLG_UV = 4;
  // key that opens customer mode
  localparam logic [31:0] UNLOCK_CODE = 32'h4F70656E;
  // values after reset
  localparam logic [31:0] WORD_RST = 32'h0000_0000;
  localparam logic [9:0] CNT_RST = 10'h000;
  // results as delivered by the datapath
  typedef struct packed {
    logic [15:0] vrms;
    logic [15:0] irms;
    logic [15:0] p_act;
    logic [15:0] p_react;
    logic [15:0] p_app;
    logic [10:0] pf;
    logic angle_lag;
    logic consuming;
    logic [9:0] n_samples;
    logic [15:0] v_inst;
    logic [15:0] i_inst;
    logic [15:0] p_inst;
  } pmr_result_t;
  // live event levels
  typedef struct packed {
    logic zero_cross;
    logic overcurrent;
    logic overvoltage;
    logic undervoltage;
  } pmr_event_t;
  // register access request
  typedef struct packed {
    logic rd;
    logic wr;
    logic [7:0] addr;
    logic [31:0] wdata;
  } pmr_req_t;
endpackage : pmr_pkg

/* src/pmr_sticky.sv */
// sticky event flag with write-one-to-clear
`timescale 1ns/100ps
module pmr_sticky (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic set_i,
  input wire logic clr_i,
  output logic flag_o
);
  // set beats clear so an event in the clear cycle survives
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      flag_o <= 1'b0;
    end else if (set_i) begin
      flag_o <= 1'b1;
    end else if (clr_i) begin
      flag_o <= 1'b0;
    end
  end

  a_sticky_hold: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    flag_o && !clr_i |=> flag_o) else $error("sticky flag dropped");
  a_sticky_set: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    set_i |=> flag_o) else $error("sticky flag not set");
endmodule : pmr_sticky

/* src/pmr_capture.sv */
// capture of one datapath result set into a coherent snapshot
`timescale 1ns/100ps
module pmr_capture (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic load_i,
  input wire pmr_pkg::pmr_result_t res_i,
  output pmr_pkg::pmr_result_t snap_o
);
  // snapshot taken only on load so a read never mixes two updates
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      snap_o <= '0;
    end else if (load_i) begin
      snap_o <= res_i;
    end
  end
endmodule : pmr_capture

/* dv/pmr_host_model.sv */
// host model: one-cycle register reads and writes on the bank port
`timescale 1ns/100ps
module pmr_host_model (
  input wire logic clk_i,
  input wire logic [31:0] rdata_i,
  input wire logic rvalid_i,
  output pmr_pkg::pmr_req_t req_o
);
  initial req_o = '0;
  // idle fields carry inverted values so stale data cannot pass
  task automatic write_word(input logic [7:0] a, input logic [31:0] d);
    req_o <= '{1'b0, 1'b1, a, d};
    @(posedge clk_i);
    req_o <= '{1'b0, 1'b0, ~a, ~d};
    @(posedge clk_i);
  endtask : write_word
  // answer taken one edge after the read edge
  task automatic read_word(input logic [7:0] a, output logic [31:0] d);
    req_o <= '{1'b1, 1'b0, a, 32'h0000_0000};
    @(posedge clk_i);
    req_o <= '{1'b0, 1'b0, ~a, 32'hFFFF_FFFF};
    @(posedge clk_i);
    // a missing answer strobe turns into a wrong word
    d = rvalid_i ? rdata_i : ~rdata_i;
  endtask : read_word
endmodule : pmr_host_model

/* dv/tb_top.sv */
// self-checking bench for the power result register bank
`timescale 1ns/100ps
module tb_top;
  logic clk_i; // 25 MHz clock
  logic rst_n_i; // sync reset, active low
  logic res_valid_i; // snapshot load strobe
  pmr_pkg::pmr_result_t res_i; // datapath results
  pmr_pkg::pmr_result_t r; // last loaded set
  pmr_pkg::pmr_event_t evt_i; // live event levels
  pmr_pkg::pmr_req_t req; // host request
  logic [31:0] rdata; // read data
  logic rvalid; // read answer strobe
  logic cmode; // customer mode level
  logic [31:0] got; // last word read
  logic [7:0] addrs [7] = '{8'h20, 8'h21, 8'h22, 8'h23, 8'h25, 8'h2D, 8'h30};
  int miscompares = 0;
  int checks = 0;
  int cycles = 0;
  pmr_bank i_dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .req_i(req), .res_valid_i(res_valid_i),
    .res_i(res_i), .evt_i(evt_i), .rdata_o(rdata), .rvalid_o(rvalid), .customer_mode_o(cmode));
  pmr_host_model i_host (.clk_i(clk_i), .rdata_i(rdata), .rvalid_i(rvalid), .req_o(req));
  // clock
  initial begin
    clk_i = 1'b0;
    forever #20 clk_i = ~clk_i;
  end
  // hang guard, far above the roughly 85 cycles needed
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 2000) begin
      miscompares++;
      give_verdict();
    end
  end
  task automatic give_verdict();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : give_verdict
  task automatic check_word(input logic [31:0] g, input logic [31:0] e);
    checks++;
    if (g !== e) begin
      miscompares++;
      $display("unexpected at %0t: got %h want %h", $time, g, e);
    end
  endtask : check_word
  // read one word and compare
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    i_host.read_word(a, got);
    check_word(got, e);
  endtask : rd_chk
  // result set with distinct rms and power fields, instantaneous fields equal to vrms; pf, flags and count chosen by caller
  function automatic pmr_pkg::pmr_result_t mk(input logic [15:0] b, input logic [10:0] pf,
      input logic lag, input logic cons, input logic [9:0] n);
    mk = '{b, ~b, b ^ 16'h8000, b + 16'h0001, ~b + 16'h0002, pf, lag, cons, n, b, b, b};
  endfunction : mk
  // read every result word of the last loaded set
  task automatic chk_all();
    rd_chk(pmr_pkg::ADDR_RMS_VI, {r.irms, r.vrms});
    rd_chk(pmr_pkg::ADDR_POWER, {r.p_react, r.p_act});
    rd_chk(pmr_pkg::ADDR_APP_PF, {3'h0, r.consuming, r.angle_lag, r.pf, r.p_app});
    rd_chk(pmr_pkg::ADDR_SAMPLES, {22'h000000, r.n_samples});
    rd_chk(pmr_pkg::ADDR_INST_VI, {r.i_inst, r.v_inst});
    rd_chk(pmr_pkg::ADDR_INST_P, {16'h0000, r.p_inst});
  endtask : chk_all
  // load a set, then read every result word
  task automatic load_chk(input pmr_pkg::pmr_result_t s);
    r = s;
    res_i <= s;
    res_valid_i <= 1'b1;
    @(posedge clk_i);
    res_valid_i <= 1'b0;
    @(posedge clk_i);
    chk_all();
  endtask : load_chk
  // main sequence
  initial begin
    rst_n_i = 1'b0;
    res_valid_i = 1'b0;
    res_i = '0;
    evt_i = '0;
    repeat (5) @(posedge clk_i);
    rst_n_i <= 1'b1;
    @(posedge clk_i);
    foreach (addrs[k]) rd_chk(addrs[k], 32'h0000_0000);
    load_chk(mk(16'h8001, 11'h400, 1'b1, 1'b0, 10'h3FF));
    load_chk(mk(16'h7FFE, 11'h3FF, 1'b0, 1'b1, 10'h000));
    // writes to result words must be ignored
    i_host.write_word(pmr_pkg::ADDR_RMS_VI, 32'hFFFF_FFFF);
    i_host.write_word(pmr_pkg::ADDR_SAMPLES, 32'hFFFF_FFFF);
    // no reload here, so a write that leaked into the snapshot shows up
    chk_all();
    // overcurrent pulse latches until written one
    evt_i <= '{1'b0, 1'b1, 1'b0, 1'b0};
    @(posedge clk_i);
    rd_chk(pmr_pkg::ADDR_FLAGS, 32'h0000_0006);
    evt_i <= '0;
    @(posedge clk_i);
    rd_chk(pmr_pkg::ADDR_FLAGS, 32'h0000_0004);
    i_host.write_word(pmr_pkg::ADDR_FLAGS, 32'h0000_0004);
    rd_chk(pmr_pkg::ADDR_FLAGS, 32'h0000_0000);
    // the other live levels land in bits 0, 3 and 4 and do not latch
    evt_i <= '{1'b1, 1'b0, 1'b1, 1'b1};
    @(posedge clk_i);
    rd_chk(pmr_pkg::ADDR_FLAGS, 32'h0000_0019);
    evt_i <= '0;
    // key opens customer mode
    i_host.write_word(pmr_pkg::ADDR_KEY, pmr_pkg::UNLOCK_CODE);
    rd_chk(pmr_pkg::ADDR_UNLOCK, 32'h0000_0001);
    rd_chk(pmr_pkg::ADDR_KEY, pmr_pkg::UNLOCK_CODE);
    check_word({31'h0, cmode}, 32'h0000_0001);
    give_verdict();
  end
endmodule : tb_top
